/* design/glf_top.sv */
// Purpose: gray shade pixel lookup and virtual line fetch
// Assumes: display memory read port answers one read at a time
// Notes:   registers over avalon-mm, one answer per request
// Contract
// [RULE_01] gray level comes only from the green field, no eight bit depth.
// [RULE_02] at one bit per pixel a byte holds eight pixels, bit selects entry 0 or 1.
// [RULE_03] at two bits per pixel only entries zero to three are used.
// [RULE_04] at two bits per pixel entries above three have no effect.
// [RULE_05] at two bits per pixel a byte holds four pixels, code picks entry 0 to 3.
// [RULE_06] at four bits per pixel the first sixteen entries are used.
// [RULE_07] at four bits per pixel each nibble is the entry index directly.
// [RULE_08] every green field holds any of sixteen levels written by software.
// [RULE_09] an 8-bit line offset register holds 0 to 255 extra words per line.
// [RULE_10] offset zero fetches lines from contiguous memory.
// [RULE_11] offset only adds to the line stride, width comes from its own register.
// [RULE_12] a memory word is sixteen bits, pixels per word is sixteen over depth.
// [RULE_13] fetch addresses stay inside the 81920-byte display memory.
// [RULE_14] the most significant pixel of each byte is shown first.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module glf_top (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_b,
    input  wire logic [7:0]   i_avs_address,
    input  wire logic         i_avs_read,
    input  wire logic         i_avs_write,
    input  wire logic [31:0]  i_avs_writedata,
    input  wire logic [3:0]   i_avs_byteenable,
    output logic [31:0]       o_avs_readdata,
    output logic              o_avs_waitrequest,
    output logic              o_mem_rd,
    output logic [15:0]       o_mem_addr,
    input  wire logic         i_mem_valid,
    input  wire logic [15:0]  i_mem_data,
    output glf_pkg::glf_pix_t o_pix,
    output logic              o_pix_valid,
    input  wire logic         i_pix_ready
);
    typedef enum logic [1:0] {FS_IDLE, FS_REQ, FS_WAIT} glf_fstate_t;

    // registers
    logic              enable;
    glf_pkg::glf_bpp_t mode;
    logic [7:0]        width;
    logic [15:0]       start;
    logic [9:0]        lines;
    logic [7:0]        offset;
    logic [3:0]        green [glf_pkg::LUT_ENTRIES];
    logic [31:0]       next_rdata;
    // fetch state
    glf_fstate_t       fstate;
    logic [15:0]       line_base;
    logic [7:0]        word_idx;
    logic [9:0]        line_idx;
    // unpack state
    logic [15:0]       sh;
    logic [4:0]        pix_left;
    logic [7:0]        uword;
    logic              last_word;

    // bus decode
    wire [5:0]  idx    = i_avs_address[7:2];
    wire        take   = !o_avs_waitrequest;
    wire        wr_acc = take && i_avs_write;
    wire        lut_hit = (idx[5:4] == glf_pkg::IDX_LUT[5:4]);
    wire        be0    = i_avs_byteenable[0];
    wire        be1    = i_avs_byteenable[1];
    wire [1:0]  wr_bpp = i_avs_writedata[glf_pkg::CTRL_BPP_LSB +: 2];
    wire        bpp_ok = (wr_bpp != 2'h3);

    // avalon answer: waitrequest drops one cycle after the request arrives
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
            o_avs_readdata    <= next_rdata;
        end
    end

    // read mux, reserved bits and unmapped indices read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (lut_hit) begin
            next_rdata[glf_pkg::GREEN_LSB +: 4] = green[idx[3:0]];
        end else begin
            case (idx)
                glf_pkg::IDX_CTRL:   next_rdata[2:0] = {mode, enable};
                glf_pkg::IDX_WIDTH:  next_rdata[7:0] = width;
                glf_pkg::IDX_START:  next_rdata[15:0] = start;
                glf_pkg::IDX_LINES:  next_rdata[9:0] = lines;
                glf_pkg::IDX_STATUS: next_rdata[10:0] = {fstate != FS_IDLE, line_idx};
                glf_pkg::IDX_OFFSET: next_rdata[7:0] = offset;
                default:             next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // control writes; a depth code without a mode is dropped whole
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable <= 1'b0;
            mode   <= glf_pkg::BPP_1;
            width  <= glf_pkg::RST_WIDTH;
            start  <= glf_pkg::RST_START;
            lines  <= glf_pkg::RST_LINES;
            offset <= glf_pkg::RST_OFFSET;
        end else if (wr_acc && be0) begin
            if (idx == glf_pkg::IDX_CTRL && bpp_ok) begin
                enable <= i_avs_writedata[glf_pkg::CTRL_EN_BIT];
                mode   <= glf_pkg::glf_bpp_t'(wr_bpp); // RULE_01
            end
            if (idx == glf_pkg::IDX_WIDTH) width <= i_avs_writedata[7:0];
            if (idx == glf_pkg::IDX_START && be1) start <= i_avs_writedata[15:0];
            if (idx == glf_pkg::IDX_LINES && be1) lines <= i_avs_writedata[9:0];
            if (idx == glf_pkg::IDX_OFFSET) offset <= i_avs_writedata[7:0]; // RULE_09
        end
    end

    // one green field per entry, red and blue are not kept at all
    genvar g;
    generate
        for (g = 0; g < glf_pkg::LUT_ENTRIES; g++) begin : g_lut
            wire hit = wr_acc && be0 && lut_hit && (idx[3:0] == 4'(g));
            always_ff @(posedge i_mclk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    green[g] <= glf_pkg::RST_GREEN;
                end else if (hit) begin
                    green[g] <= i_avs_writedata[glf_pkg::GREEN_LSB +: 4]; // RULE_08
                end
            end
        end
    endgenerate

    // fetch address arithmetic, wrapping inside display memory
    wire [16:0] raw_addr  = {1'b0, line_base} + {9'h000, word_idx};
    wire [16:0] next_addr = (raw_addr >= glf_pkg::MEM_WORDS) ? raw_addr - glf_pkg::MEM_WORDS : raw_addr; // RULE_13
    wire [16:0] raw_next  = {1'b0, line_base} + {9'h000, width} + {9'h000, offset}; // RULE_10 RULE_11
    wire [16:0] wrap_next = (raw_next >= glf_pkg::MEM_WORDS) ? raw_next - glf_pkg::MEM_WORDS : raw_next; // RULE_13
    wire        word_end  = (word_idx == width - 8'h01);
    wire        frame_end = (line_idx == lines - 10'h001);
    wire        fifo_in_ready;
    wire        fifo_push = (fstate == FS_WAIT) && i_mem_valid;
    wire        can_start = enable && (width != 8'h00) && (lines != 10'h000);

    // fetch engine: one read in flight, issued only with room in the fifo
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fstate     <= FS_IDLE;
            line_base  <= 16'h0000;
            word_idx   <= 8'h00;
            line_idx   <= 10'h000;
            o_mem_rd   <= 1'b0;
            o_mem_addr <= 16'h0000;
        end else begin
            o_mem_rd <= 1'b0;
            case (fstate)
                FS_IDLE: begin
                    if (can_start) begin
                        line_base <= start;
                        word_idx  <= 8'h00;
                        line_idx  <= 10'h000;
                        fstate    <= FS_REQ;
                    end
                end
                FS_REQ: begin
                    if (!can_start) begin
                        fstate <= FS_IDLE;
                    end else if (fifo_in_ready) begin
                        o_mem_rd   <= 1'b1;
                        o_mem_addr <= next_addr[15:0];
                        fstate     <= FS_WAIT;
                    end
                end
                FS_WAIT: begin
                    if (i_mem_valid) begin
                        fstate <= FS_REQ;
                        if (!word_end) begin
                            word_idx <= word_idx + 8'h01;
                        end else if (frame_end) begin
                            word_idx  <= 8'h00;
                            line_idx  <= 10'h000;
                            line_base <= start;
                        end else begin
                            word_idx  <= 8'h00;
                            line_idx  <= line_idx + 10'h001;
                            line_base <= wrap_next[15:0]; // RULE_11
                        end
                    end
                end
                default: fstate <= FS_IDLE;
            endcase
        end
    end

    // word buffer between memory and pixel unpacking
    wire        fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire        load = fifo_out_valid && (pix_left == 5'h00);
    glf_fifo #(
        .W (glf_pkg::WORD_BITS),
        .D (glf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (i_mem_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (pix_left == 5'h00),
        .o_out_data  (fifo_out_data)
    );

    // pixel index from the top bits of the word, 16 / bpp pixels per word
    wire [4:0] ppw = (mode == glf_pkg::BPP_1) ? 5'h10 :
                     (mode == glf_pkg::BPP_2) ? 5'h08 : 5'h04; // RULE_12
    wire [3:0] cur_idx = (mode == glf_pkg::BPP_1) ? {3'h0, sh[15]} :     // RULE_02
                         (mode == glf_pkg::BPP_2) ? {2'h0, sh[15:14]} :  // RULE_03 RULE_04 RULE_05
                                                     sh[15:12];          // RULE_06 RULE_07
    wire [15:0] sh_next = (mode == glf_pkg::BPP_1) ? {sh[14:0], 1'b0} :
                          (mode == glf_pkg::BPP_2) ? {sh[13:0], 2'h0} : {sh[11:0], 4'h0}; // RULE_14
    wire        emit = (pix_left != 5'h00) && (!o_pix_valid || i_pix_ready);

    // unpack and look up; output stalls the fifo, which stalls the fetch
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sh          <= 16'h0000;
            pix_left    <= 5'h00;
            uword       <= 8'h00;
            last_word   <= 1'b0;
            o_pix       <= '0;
            o_pix_valid <= 1'b0;
        end else begin
            if (load) begin
                sh        <= fifo_out_data;
                pix_left  <= ppw; // RULE_12
                last_word <= (uword == width - 8'h01);
                uword     <= (uword == width - 8'h01) ? 8'h00 : uword + 8'h01;
            end else if (emit) begin
                sh       <= sh_next; // RULE_14
                pix_left <= pix_left - 5'h01;
            end
            if (emit) begin
                o_pix.gray     <= green[cur_idx]; // RULE_01
                o_pix.line_end <= last_word && (pix_left == 5'h01);
                o_pix_valid    <= 1'b1;
            end else if (i_pix_ready) begin
                o_pix_valid <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    sequence s_req_waiting;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_answer;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    a_bus_answer: assert property (s_req_waiting |=> s_answer)
        else $error("avalon answer not one cycle after request");
    a_offset_store: assert property (wr_acc && be0 && idx == glf_pkg::IDX_OFFSET // RULE_09
        |=> offset == $past(i_avs_writedata[7:0]))
        else $error("line offset not stored");
    a_green_store: assert property (wr_acc && be0 && lut_hit // RULE_08
        |=> green[$past(idx[3:0])] == $past(i_avs_writedata[7:4]))
        else $error("green level not stored");
    a_no_eight_bpp: assert property (mode != 2'h3) // RULE_01
        else $error("unsupported depth code held");
    a_gray_green: assert property (emit |=> o_pix.gray == $past(green[cur_idx])) // RULE_01
        else $error("gray level not from green field");
    a_one_bpp_idx: assert property (emit && mode == glf_pkg::BPP_1 |-> cur_idx[3:1] == 3'h0) // RULE_02
        else $error("one bit pixel reached past entry 1");
    a_two_bpp_idx: assert property (emit && mode == glf_pkg::BPP_2 |-> cur_idx[3:2] == 2'h0) // RULE_04
        else $error("two bit pixel reached past entry 3");
    a_word_pixels: assert property (load |=> pix_left == (5'h10 >> $past(mode))) // RULE_12
        else $error("wrong pixel count per word");
    a_msb_first: assert property (load ##1 emit |-> cur_idx == (sh[15:12] >> (3'h4 - (3'h1 << mode)))) // RULE_14
        else $error("first pixel not from top bits");
    a_line_stride: assert property (fstate == FS_WAIT && i_mem_valid && word_end && !frame_end // RULE_10
        |=> line_base == $past(wrap_next[15:0]))
        else $error("line stride not width plus offset");
    a_addr_range: assert property (o_mem_rd |-> {1'b0, o_mem_addr} < glf_pkg::MEM_WORDS) // RULE_13
        else $error("fetch address outside display memory");
endmodule : glf_top
`default_nettype wire

/* design/glf_pkg.sv */
// Purpose: shared constants and types of the gray lut line fetch block
// Assumes: one clock domain, 32-bit avalon register bus
// Notes:   register offsets are word indices, byte address is four times
package glf_pkg;
    // register indices
    localparam logic [5:0] IDX_CTRL   = 6'h00;
    localparam logic [5:0] IDX_WIDTH  = 6'h01;
    localparam logic [5:0] IDX_START  = 6'h02;
    localparam logic [5:0] IDX_LINES  = 6'h03;
    localparam logic [5:0] IDX_STATUS = 6'h04;
    localparam logic [5:0] IDX_OFFSET = 6'h11;
    localparam logic [5:0] IDX_LUT    = 6'h20;
    // field positions
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_BPP_LSB = 1;
    localparam int GREEN_LSB    = 4;
    // reset values
    localparam logic [7:0]  RST_OFFSET = 8'h00;
    localparam logic [7:0]  RST_WIDTH  = 8'h00;
    localparam logic [15:0] RST_START  = 16'h0000;
    localparam logic [9:0]  RST_LINES  = 10'h000;
    localparam logic [3:0]  RST_GREEN  = 4'h0;
    // geometry
    localparam int          LUT_ENTRIES = 16;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          WORD_BITS   = 16;
    localparam logic [16:0] MEM_WORDS   = 17'h0A000;
    // depth codes, eight bits per pixel has no code
    typedef enum logic [1:0] {
        BPP_1 = 2'h0,
        BPP_2 = 2'h1,
        BPP_4 = 2'h2
    } glf_bpp_t;
    typedef struct packed {
        logic       line_end;
        logic [3:0] gray;
    } glf_pix_t;
endpackage : glf_pkg

/* design/glf_fifo.sv */
// Purpose: flip-flop fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   full and empty come from a separate occupancy count
`timescale 1ns/10ps
`default_nettype none
module glf_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_b,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    wire           push = i_in_valid && o_in_ready;
    wire           pop  = o_out_valid && i_out_ready;

    // honest flags straight from the count
    assign o_in_ready  = (count != D[AW:0]);
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];

    // storage carries no reset, it is never read while empty
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : glf_fifo
`default_nettype wire

/* test/glf_mem_model.sv */
// Purpose: display memory model that answers the block's word reads
// Assumes: one read outstanding, answer one or four cycles after the read pulse
// Notes:   the data bus inverts every idle cycle so stale words never pass
`timescale 1ns/10ps
`default_nettype none
module glf_mem_model (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_slow,
    output logic             o_valid,
    output logic [15:0]      o_data
);
    logic        pend;
    logic [1:0]  wait_cnt;
    logic [15:0] addr;

    // word contents follow the low address byte, so a fetch misplaced by less than 256 words shows
    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return {a[7:0], a[7:0] ^ 8'hA5};
    endfunction : mem_word

    // slow mode waits three extra cycles before answering
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend     <= 1'b0;
            wait_cnt <= 2'h0;
            addr     <= 16'h0000;
            o_valid  <= 1'b0;
            o_data   <= 16'hFFFF;
        end else begin
            o_valid <= 1'b0;
            o_data  <= ~o_data; // released bus, never holds the last word
            if (i_rd) begin
                pend     <= 1'b1;
                addr     <= i_addr;
                wait_cnt <= i_slow ? 2'h3 : 2'h0;
            end else if (pend && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (pend) begin
                pend    <= 1'b0;
                o_valid <= 1'b1;
                o_data  <= mem_word(addr);
            end
        end
    end
endmodule : glf_mem_model
`default_nettype wire

/* test/glf_top_bench.sv */
// Purpose: self-checking bench of the gray lookup and line fetch block
// Assumes: memory model answers each read, pixels logged at the take edge
// Notes:   every scenario starts from a fresh reset
`timescale 1ns/10ps
`default_nettype none
module glf_top_bench;
    logic              i_mclk;
    logic              i_rst_b;
    logic [7:0]        avs_addr;
    logic              avs_rd;
    logic              avs_wr;
    logic [31:0]       avs_wdata;
    logic [3:0]        avs_be;
    logic [31:0]       avs_rdata;
    logic              avs_wait;
    logic              mem_rd;
    logic [15:0]       mem_addr;
    logic              mem_valid;
    logic [15:0]       mem_data;
    glf_pkg::glf_pix_t pix;
    logic              pix_valid;
    logic              pix_ready;
    logic              slow;
    int                errors;
    int                num_checks;
    int                cycles;
    logic [15:0]       addrq[$];
    glf_pkg::glf_pix_t pixq[$];

    glf_top dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_avs_address(avs_addr), .i_avs_read(avs_rd),
        .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be),
        .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .o_mem_rd(mem_rd),
        .o_mem_addr(mem_addr), .i_mem_valid(mem_valid), .i_mem_data(mem_data), .o_pix(pix),
        .o_pix_valid(pix_valid), .i_pix_ready(pix_ready));
    glf_mem_model mem (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_rd(mem_rd), .i_addr(mem_addr),
        .i_slow(slow), .o_valid(mem_valid), .o_data(mem_data));

    // clock at 100 MHz
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // log fetch addresses and taken pixels, cut a hang short
    always @(posedge i_mclk) begin
        if (mem_rd === 1'b1) begin
            addrq.push_back(mem_addr);
        end
        if (pix_valid === 1'b1 && pix_ready) begin
            pixq.push_back(pix);
        end
        cycles++;
        if (cycles > 60000) begin
            errors++;
            stop_test();
        end
    end

    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return {a[7:0], a[7:0] ^ 8'hA5};
    endfunction : mem_word

    // distinct level per entry so a wrong index always shows
    function automatic logic [3:0] lut_val(input int i);
        return 4'(i * 7 + 3);
    endfunction : lut_val

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task do_reset();
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        addrq.delete();
        pixq.delete();
    endtask : do_reset

    // request held until waitrequest is sampled low
    task bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        avs_addr  <= a;
        avs_wdata <= d;
        avs_wr    <= 1'b1;
        do @(posedge i_mclk); while (avs_wait !== 1'b0);
        avs_wr <= 1'b0;
    endtask : bus_write

    task bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        avs_addr <= a;
        avs_rd   <= 1'b1;
        do @(posedge i_mclk); while (avs_wait !== 1'b0);
        d = avs_rdata;
        avs_rd <= 1'b0;
    endtask : bus_read

    task test_regs();
        logic [31:0] r;
        do_reset();
        bus_read(8'h44, r);
        check("offset reset", 32'h0, r);
        bus_write(8'h44, 32'h000001FF);
        bus_read(8'h44, r);
        check("offset max", 32'hFF, r);
        // a write without lane 0 must leave the offset alone
        avs_be <= 4'hE;
        bus_write(8'h44, 32'h00000012);
        avs_be <= 4'hF;
        bus_read(8'h44, r);
        check("offset lane off", 32'hFF, r);
        bus_read(8'h10, r);
        check("status idle", 32'h0, r);
        bus_read(8'hFC, r);
        check("unmapped", 32'h0, r);
        for (int k = 0; k < 16; k++) begin
            bus_write(8'h80 + 8'(4 * k), {24'h0, 4'(k), 4'hF});
            bus_read(8'h80 + 8'(4 * k), r);
            check("lut level", {24'h0, 4'(k), 4'h0}, r);
        end
        bus_write(8'h00, 32'h7);
        bus_read(8'h00, r);
        check("depth code 3", 32'h0, r);
        $display("test registers done");
    endtask : test_regs

    // program, enable, optionally stall the sink, then compare addresses and pixels
    task run_cfg(input string name, input logic [1:0] depth, input int width, lines, start, off,
                 input logic stall);
        int          bpp;
        int          ppw;
        int          nw;
        int          k;
        int          a;
        logic [15:0] d;
        logic [3:0]  idx;
        do_reset();
        for (k = 0; k < 16; k++) bus_write(8'h80 + 8'(4 * k), {24'h0, lut_val(k), 4'h0});
        bus_write(8'h04, 32'(width));
        bus_write(8'h08, 32'(start));
        bus_write(8'h0C, 32'(lines));
        bus_write(8'h44, 32'(off));
        pix_ready <= !stall;
        slow      <= stall;
        bus_write(8'h00, {29'h0, depth, 1'b1});
        bpp = 1 << depth;
        ppw = 16 / bpp;
        nw  = width * (lines + 1);
        if (stall) begin
            repeat (300) @(posedge i_mclk);
            k = addrq.size();
            repeat (60) @(posedge i_mclk);
            check({name, " fill"}, 32'h1, 32'(k >= glf_pkg::FIFO_DEPTH));
            check({name, " refuse"}, 32'(k), 32'(addrq.size()));
            pix_ready <= 1'b1;
        end
        while (pixq.size() < nw * ppw) @(posedge i_mclk);
        for (k = 0; k < nw; k++) begin
            a = (start + ((k / width) % lines) * (width + off) + k % width) % 40960;
            check({name, " addr"}, 32'(a), 32'(addrq[k]));
            d = mem_word(16'(a));
            for (int j = 0; j < ppw; j++) begin
                idx = 4'((d >> (16 - (j + 1) * bpp)) & ((1 << bpp) - 1));
                check({name, " pixel"}, {27'h0, j == ppw - 1 && k % width == width - 1, lut_val(idx)},
                      32'(pixq[k * ppw + j]));
            end
        end
        $display("test %s done", name);
    endtask : run_cfg

    // main sequence
    initial begin
        errors     = 0;
        num_checks = 0;
        cycles     = 0;
        i_rst_b   <= 1'b0;
        avs_addr  <= 8'h00;
        avs_rd    <= 1'b0;
        avs_wr    <= 1'b0;
        avs_wdata <= 32'h0;
        avs_be    <= 4'hF;
        pix_ready <= 1'b1;
        slow      <= 1'b0;
        test_regs();
        run_cfg("gray4 contiguous", glf_pkg::BPP_4, 2, 3, 16'h0100, 0, 1'b0);
        run_cfg("gray4 stride", glf_pkg::BPP_4, 2, 3, 16'h0100, 3, 1'b0);
        run_cfg("gray2 stride", glf_pkg::BPP_2, 3, 2, 16'h0020, 255, 1'b0);
        run_cfg("gray1 fill", glf_pkg::BPP_1, 8, 4, 16'h0040, 1, 1'b1);
        run_cfg("gray4 wrap", glf_pkg::BPP_4, 2, 2, 16'h9FFE, 0, 1'b0);
        stop_test();
    end
endmodule : glf_top_bench
`default_nettype wire
